// file: rtl/fsp_pkg.sv
package fsp_pkg;
  // flash geometry
  localparam int ROW_WORDS      = 32;
  localparam int ROWS_PER_PANEL = 128;
  localparam int INSTR_W        = 24;
  localparam int REG_W          = 16;
  localparam int ADDR_W         = 24;

  // register selects on the link
  localparam logic [1:0] SEL_CONTROL   = 2'h0;
  localparam logic [1:0] SEL_ADDR_LOW  = 2'h1;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h2;
  localparam logic [1:0] SEL_KEY       = 2'h3;

  // control register layout
  localparam int CTL_START_BIT = 15;
  localparam int CTL_OP_WRITE_ENABLE_BIT  = 14;
  localparam int CTL_ERR_BIT   = 13;
  localparam int OPC_W         = 7;
  localparam logic [6:0] OPC_ROW_ERASE   = 7'h41;
  localparam logic [6:0] OPC_ROW_PROGRAM = 7'h01;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;

  // unlock values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // timing
  localparam int OP_TIME_NS    = 2000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int NOP_SLOTS     = 2;

  // host-side apb map
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_CMD    = 12'h000;
  localparam logic [11:0] OFS_ADDR   = 12'h004;
  localparam logic [11:0] OFS_WDATA  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_IRQCLR = 12'h010;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_IRQ_BIT   = 1;
  localparam int ST_STALL_BIT = 2;
  localparam int ST_ERR_BIT   = 3;
  localparam int ST_RDATA_LSB = 16;

  typedef enum logic [1:0] {
    KEY_NONE  = 2'b00,
    KEY_HALF  = 2'b01,
    KEY_ARMED = 2'b10
  } fsp_key_t;

  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_ERASE   = 2'b01,
    OP_PROGRAM = 2'b10
  } fsp_op_t;

  typedef enum logic [2:0] {
    CMD_NONE         = 3'h0,
    CMD_REG_WRITE    = 3'h1,
    CMD_REG_READ     = 3'h2,
    CMD_TBL_LOW      = 3'h3,
    CMD_TBL_HIGH     = 3'h4,
    CMD_UNLOCK_START = 3'h5
  } fsp_cmd_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_TW    = 3'h1,
    H_RG    = 3'h2,
    H_KEY1  = 3'h3,
    H_KEY2  = 3'h4,
    H_NOP   = 3'h5
  } fsp_hst_t;
endpackage

// file: rtl/fsp_link_if.sv
`timescale 1ns/10ps
interface fsp_link_if;
  logic        tw_valid;
  logic        tw_high;
  logic [23:0] tw_addr;
  logic [15:0] tw_data;
  logic        tw_done;
  logic        rg_valid;
  logic        rg_write;
  logic [1:0]  rg_sel;
  logic [15:0] rg_wdata;
  logic [15:0] rg_rdata;
  logic        rg_done;
  logic        stall;
  logic        done_irq;
  logic        irq_clear;

  modport dev (
    input  tw_valid, tw_high, tw_addr, tw_data, rg_valid, rg_write, rg_sel, rg_wdata, irq_clear,
    output tw_done, rg_rdata, rg_done, stall, done_irq
  );
  modport host (
    output tw_valid, tw_high, tw_addr, tw_data, rg_valid, rg_write, rg_sel, rg_wdata, irq_clear,
    input  tw_done, rg_rdata, rg_done, stall, done_irq
  );
endinterface

// file: rtl/fsp_device.sv
// Contract
// - rows of 32 words, 128-row panels
// - erase clears one row, program writes 32
// - program data comes only from latches
// - software loads latches ascending, row-aligned
// - table write fills latch, two cycles
// - low address captures table EA[15:0]
// - high address captures table EA[23:16]
// - direct address writes override captured value
// - key 0x55 then 0xAA, write-only
// - start bit 15 starts, self-clears
// - 2 ms cycle, core stalled throughout
// - control selects operation, carries start
// - erase sequence order set by software
// - program sequence order set by software
// - two idle slots after start
// - low and high table writes pair
// - high write keeps low byte only
// - software cannot clear start bit
// - external reset aborts, sets error flag
// - done flag sticky until software clear
// - control layout, resets to zero
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module fsp_device
  import fsp_pkg::*;
#(
  parameter int OP_CYCLES_P = fsp_pkg::OP_CYCLES
) (
  // clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  // master or watchdog reset event
  input  wire logic                   ext_reset_in,
  // core side
  fsp_link_if.dev                     lk,
  // flash array side
  output logic                        arr_erase_out,
  output logic                        arr_prog_out,
  output logic [10:0]                 arr_panel_out,
  output logic [6:0]                  arr_row_out,
  output logic [4:0]                  arr_word_idx_out,
  output logic [fsp_pkg::INSTR_W-1:0] arr_word_data_out,
  output logic                        busy_out
);
  import fsp_pkg::*;

  localparam int CNT_W = $clog2(OP_CYCLES_P + 1);

  generate
    if (OP_CYCLES_P < ROW_WORDS + 1) begin : g_bad_cycles
      $error("operation too short to stream a row");
    end
  endgenerate

  typedef struct packed {
    fsp_op_t                             op;
    logic                                start;
    logic                                op_write_enable;
    logic                                err;
    logic [OPC_W-1:0]                    opcode;
    logic [REG_W-1:0]                    addr_low;
    logic [7:0]                          addr_high;
    fsp_key_t                            key;
    logic [ROW_WORDS-1:0][INSTR_W-1:0]   latch;
    logic                                tw_busy;
    logic                                tw_done;
    logic                                rg_done;
    logic [REG_W-1:0]                    rg_rdata;
    logic [CNT_W-1:0]                    op_cnt;
    logic [5:0]                          word_idx;
    logic                                stall;
    logic                                irq;
    logic                                arr_erase;
    logic                                arr_prog;
    logic [10:0]                         arr_panel;
    logic [6:0]                          arr_row;
    logic [4:0]                          arr_idx;
    logic [INSTR_W-1:0]                  arr_data;
  } fsp_dev_t;

  fsp_dev_t s;
  fsp_dev_t next_s;

  function automatic logic [4:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = a[5:1];
  endfunction

  function automatic logic [REG_W-1:0] control_word(input fsp_dev_t v);
    control_word = {v.start, v.op_write_enable, v.err, 6'h00, v.opcode};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s           = s;
    next_s.tw_done   = 1'b0;
    next_s.rg_done   = 1'b0;
    next_s.arr_erase = 1'b0;
    next_s.arr_prog  = 1'b0;

    // latch write, done after two cycles
    if (s.tw_busy) begin
      next_s.tw_busy = 1'b0;
      next_s.tw_done = 1'b1;
    end else if (lk.tw_valid && !s.tw_done && s.op == OP_IDLE) begin
      next_s.tw_busy = 1'b1;
      next_s.key     = KEY_NONE;
      if (lk.tw_high) begin
        next_s.latch[word_of(lk.tw_addr)][23:16] = lk.tw_data[7:0];
      end else begin
        next_s.latch[word_of(lk.tw_addr)][15:0] = lk.tw_data;
      end
      next_s.addr_low  = lk.tw_addr[15:0];
      next_s.addr_high = lk.tw_addr[23:16];
    end

    // register access, held off while an operation runs
    if (lk.rg_valid && !s.rg_done && s.op == OP_IDLE) begin
      next_s.rg_done  = 1'b1;
      next_s.rg_rdata = 16'h0000;
      next_s.key      = KEY_NONE;
      if (!lk.rg_write) begin
        case (lk.rg_sel)
          SEL_CONTROL:   next_s.rg_rdata = control_word(s);
          SEL_ADDR_LOW:  next_s.rg_rdata = s.addr_low;
          SEL_ADDR_HIGH: next_s.rg_rdata = {8'h00, s.addr_high};
          default:       next_s.rg_rdata = 16'h0000;
        endcase
      end else begin
        case (lk.rg_sel)
          SEL_CONTROL: begin
            next_s.op_write_enable   = lk.rg_wdata[CTL_OP_WRITE_ENABLE_BIT];
            next_s.err    = lk.rg_wdata[CTL_ERR_BIT];
            next_s.opcode = lk.rg_wdata[OPC_W-1:0];
            // start needs armed key and enable
            if (lk.rg_wdata[CTL_START_BIT] && s.key == KEY_ARMED && lk.rg_wdata[CTL_OP_WRITE_ENABLE_BIT] &&
                (lk.rg_wdata[OPC_W-1:0] == OPC_ROW_ERASE || lk.rg_wdata[OPC_W-1:0] == OPC_ROW_PROGRAM)) begin
              next_s.start     = 1'b1;
              next_s.op        = (lk.rg_wdata[OPC_W-1:0] == OPC_ROW_ERASE) ? OP_ERASE : OP_PROGRAM;
              next_s.op_cnt    = '0;
              next_s.word_idx  = 6'h00;
              next_s.stall     = 1'b1;
              next_s.arr_panel = {s.addr_high, s.addr_low[15:13]};
              next_s.arr_row   = s.addr_low[12:6];
            end
          end
          SEL_ADDR_LOW:  next_s.addr_low  = lk.rg_wdata;
          SEL_ADDR_HIGH: next_s.addr_high = lk.rg_wdata[7:0];
          default: begin
            // 0x55 then 0xAA back to back
            if (lk.rg_wdata[7:0] == KEY_FIRST) begin
              next_s.key = KEY_HALF;
            end else if (lk.rg_wdata[7:0] == KEY_SECOND && s.key == KEY_HALF) begin
              next_s.key = KEY_ARMED;
            end
          end
        endcase
      end
    end

    if (lk.irq_clear) begin
      next_s.irq = 1'b0;
    end

    case (s.op)
      OP_ERASE, OP_PROGRAM: begin
        next_s.op_cnt = CNT_W'(s.op_cnt + 1'b1);
        // one row erased in one pulse
        if (s.op == OP_ERASE && s.op_cnt == '0) begin
          next_s.arr_erase = 1'b1;
        end
        if (s.op == OP_PROGRAM && s.word_idx < 6'(ROW_WORDS)) begin
          next_s.arr_prog = 1'b1;
          next_s.arr_idx  = s.word_idx[4:0];
          next_s.arr_data = s.latch[s.word_idx[4:0]];
          next_s.word_idx = 6'(s.word_idx + 1'b1);
        end
        if (s.op_cnt == CNT_W'(OP_CYCLES_P - 1)) begin
          next_s.op    = OP_IDLE;
          next_s.start = 1'b0;
          next_s.stall = 1'b0;
          next_s.irq   = 1'b1;
        end
        // abort on reset event, address kept
        if (ext_reset_in) begin
          next_s.op    = OP_IDLE;
          next_s.start = 1'b0;
          next_s.stall = 1'b0;
          next_s.err   = 1'b1;
          next_s.irq   = s.irq && !lk.irq_clear;
        end
      end
      default: begin
        next_s.op_cnt = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s           <= '0;
      s.op        <= OP_IDLE;
      s.key       <= KEY_NONE;
      s.addr_low  <= ADDR_RESET;
      s.addr_high <= ADDR_RESET[7:0];
    end else begin
      s <= next_s;
    end
  end

  assign lk.tw_done        = s.tw_done;
  assign lk.rg_done        = s.rg_done;
  assign lk.rg_rdata       = s.rg_rdata;
  assign lk.stall          = s.stall;
  assign lk.done_irq       = s.irq;
  assign arr_erase_out     = s.arr_erase;
  assign arr_prog_out      = s.arr_prog;
  assign arr_panel_out     = s.arr_panel;
  assign arr_row_out       = s.arr_row;
  assign arr_word_idx_out  = s.arr_idx;
  assign arr_word_data_out = s.arr_data;
  assign busy_out          = s.stall;
endmodule

// file: rtl/fsp_host.sv
`timescale 1ns/10ps
module fsp_host
  import fsp_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       nrst_in,
  // apb slave
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [fsp_pkg::APB_AW-1:0] paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic [31:0]                     prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  // flash block
  fsp_link_if.host                        lk
);
  import fsp_pkg::*;

  typedef struct packed {
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic [ADDR_W-1:0]  addr;
    logic [REG_W-1:0]   wdata;
    logic [REG_W-1:0]   rdata;
    fsp_hst_t           st;
    logic [1:0]         nop_cnt;
    logic               tw_valid;
    logic               tw_high;
    logic               rg_valid;
    logic               rg_write;
    logic [1:0]         rg_sel;
    logic [REG_W-1:0]   rg_wdata;
    logic               irq_clear;
  } fsp_hst_state_t;

  fsp_hst_state_t s;
  fsp_hst_state_t next_s;

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    mapped = (a == OFS_CMD) || (a == OFS_ADDR) || (a == OFS_WDATA) || (a == OFS_STATUS) || (a == OFS_IRQCLR);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s           = s;
    next_s.pready    = 1'b0;
    next_s.irq_clear = 1'b0;

    // one wait state so every apb output is registered
    if (psel_in && penable_in && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped(paddr_in);
      next_s.prdata  = 32'h00000000;
      if (!pwrite_in) begin
        case (paddr_in)
          OFS_ADDR:   next_s.prdata = {8'h00, s.addr};
          OFS_WDATA:  next_s.prdata = {16'h0000, s.wdata};
          OFS_STATUS: begin
            next_s.prdata[ST_RDATA_LSB +: REG_W] = s.rdata;
            next_s.prdata[ST_BUSY_BIT]  = (s.st != H_IDLE);
            next_s.prdata[ST_IRQ_BIT]   = lk.done_irq;
            next_s.prdata[ST_STALL_BIT] = lk.stall;
          end
          default:    next_s.prdata = 32'h00000000;
        endcase
      end
    end

    case (s.st)
      H_TW: begin
        if (lk.tw_done) begin
          next_s.tw_valid = 1'b0;
          next_s.st       = H_IDLE;
        end
      end
      H_RG: begin
        if (lk.rg_done) begin
          next_s.rg_valid = 1'b0;
          next_s.rdata    = lk.rg_rdata;
          next_s.nop_cnt  = 2'h0;
          // idle slots after a start write
          next_s.st = (s.rg_write && s.rg_sel == SEL_CONTROL && s.rg_wdata[CTL_START_BIT]) ? H_NOP : H_IDLE;
        end
      end
      H_KEY1: begin
        if (lk.rg_done) begin
          next_s.rg_wdata = {8'h00, KEY_SECOND};
          next_s.st       = H_KEY2;
        end
      end
      H_KEY2: begin
        // start directly after the key pair
        if (lk.rg_done) begin
          next_s.rg_sel   = SEL_CONTROL;
          next_s.rg_wdata = s.wdata | (16'h0001 << CTL_START_BIT);
          next_s.st       = H_RG;
        end
      end
      H_NOP: begin
        if (s.nop_cnt < 2'(NOP_SLOTS)) begin
          next_s.nop_cnt = 2'(s.nop_cnt + 1'b1);
        end else if (!lk.stall) begin
          next_s.st = H_IDLE;
        end
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase

    // writes take effect on the completing apb edge
    if (psel_in && penable_in && s.pready && pwrite_in) begin
      case (paddr_in)
        OFS_ADDR:   next_s.addr      = pwdata_in[ADDR_W-1:0];
        OFS_WDATA:  next_s.wdata     = pwdata_in[REG_W-1:0];
        OFS_IRQCLR: next_s.irq_clear = pwdata_in[0];
        OFS_CMD: begin
          // commands while busy are dropped
          if (s.st == H_IDLE) begin
            case (pwdata_in[2:0])
              CMD_REG_WRITE, CMD_REG_READ: begin
                next_s.rg_valid = 1'b1;
                next_s.rg_write = (pwdata_in[2:0] == CMD_REG_WRITE);
                next_s.rg_sel   = s.addr[1:0];
                next_s.rg_wdata = s.wdata;
                next_s.st       = H_RG;
              end
              // low and high writes issued singly
              CMD_TBL_LOW, CMD_TBL_HIGH: begin
                next_s.tw_valid = 1'b1;
                next_s.tw_high  = (pwdata_in[2:0] == CMD_TBL_HIGH);
                next_s.st       = H_TW;
              end
              CMD_UNLOCK_START: begin
                next_s.rg_valid = 1'b1;
                next_s.rg_write = 1'b1;
                next_s.rg_sel   = SEL_KEY;
                next_s.rg_wdata = {8'h00, KEY_FIRST};
                next_s.st       = H_KEY1;
              end
              default: next_s.st = H_IDLE;
            endcase
          end
        end
        default: next_s.st = next_s.st;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s    <= '0;
      s.st <= H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_out   = s.prdata;
  assign pready_out   = s.pready;
  assign pslverr_out  = s.pslverr;
  assign lk.tw_valid  = s.tw_valid;
  assign lk.tw_high   = s.tw_high;
  assign lk.tw_addr   = s.addr;
  assign lk.tw_data   = s.wdata;
  assign lk.rg_valid  = s.rg_valid;
  assign lk.rg_write  = s.rg_write;
  assign lk.rg_sel    = s.rg_sel;
  assign lk.rg_wdata  = s.rg_wdata;
  assign lk.irq_clear = s.irq_clear;
endmodule

// file: bench/fsp_checker.sv
`timescale 1ns/10ps
module fsp_checker
  import fsp_pkg::*;
#(
  parameter int OP_CYCLES_P = 40
) (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic        ext_reset_in,
  // link signals
  input wire logic        tw_valid,
  input wire logic        tw_done,
  input wire logic        rg_valid,
  input wire logic        rg_write,
  input wire logic [1:0]  rg_sel,
  input wire logic [15:0] rg_wdata,
  input wire logic [15:0] rg_rdata,
  input wire logic        rg_done,
  input wire logic        stall,
  input wire logic        done_irq,
  input wire logic        irq_clear
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  logic [1:0]  key;
  logic [19:0] cnt;
  logic        take;
  logic        kw;
  logic        start;
  logic        ok;
  assign take  = rg_valid && !rg_done && !stall;
  assign kw    = take && rg_write && rg_sel == SEL_KEY;
  assign start = take && rg_write && rg_sel == SEL_CONTROL && rg_wdata[CTL_START_BIT];
  assign ok    = key == 2'h2 && rg_wdata[CTL_OP_WRITE_ENABLE_BIT]
                 && (rg_wdata[6:0] == OPC_ROW_ERASE || rg_wdata[6:0] == OPC_ROW_PROGRAM);

  ////////////////////////////////////////
  // any access between the two keys breaks the arming
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      key <= 2'h0;
      cnt <= 20'h0;
    end else begin
      cnt <= stall ? cnt + 20'h1 : 20'h0;
      if (kw && rg_wdata[7:0] == KEY_FIRST) begin
        key <= 2'h1;
      end else if (kw && key == 2'h1 && rg_wdata[7:0] == KEY_SECOND) begin
        key <= 2'h2;
      end else if (take || tw_done) begin
        key <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////
  AST_TW_LATENCY: assert property ($rose(tw_valid) && !stall |-> !tw_done ##1 !tw_done ##1 tw_done)
    else $error("table write answer not two cycles after request");
  AST_TW_PULSE: assert property (tw_done |=> !tw_done)
    else $error("table write done longer than one cycle");
  AST_RG_ANSWER: assert property (take |=> rg_done)
    else $error("register access not answered next cycle");
  AST_KEY_READ: assert property (rg_done && !$past(rg_write) && $past(rg_sel) == SEL_KEY |-> rg_rdata == 16'h0000)
    else $error("key register readable");
  AST_START_OK: assert property (start && ok |=> stall && rg_done)
    else $error("armed start did not begin operation");
  AST_START_REFUSE: assert property (start && !ok |=> !stall ##1 !stall)
    else $error("unarmed start began operation");
  AST_STALL_MAX: assert property (stall |-> cnt < OP_CYCLES_P)
    else $error("stall longer than operation time");
  AST_STALL_FULL: assert property ($fell(stall) && !$past(ext_reset_in) && !$past(ext_reset_in, 2)
    |-> cnt >= OP_CYCLES_P - 1)
    else $error("operation ended early");
  AST_DONE_SET: assert property ($fell(stall) && !$past(ext_reset_in) && !$past(ext_reset_in, 2)
    |-> done_irq)
    else $error("done flag not set at completion");
  AST_DONE_STICKY: assert property (done_irq && !irq_clear |=> done_irq)
    else $error("done flag dropped without clear");
  AST_DONE_CLEAR: assert property (irq_clear && !stall |=> !done_irq)
    else $error("done flag not cleared");
  AST_STALL_QUIET: assert property (stall && $past(stall) |-> !tw_done && !rg_done)
    else $error("link answered during operation");
  AST_ABORT: assert property (ext_reset_in && stall |-> ##[1:3] !stall)
    else $error("operation not aborted by reset event");

  COV_START: cover property (start && ok);
  COV_REFUSE: cover property (start && !ok);
  COV_DONE: cover property ($fell(stall) && done_irq);
  COV_CLEAR: cover property (irq_clear && done_irq);
endmodule

// file: bench/flash_row_self_programming_tb.sv
`timescale 1ns/10ps
module flash_row_self_programming_tb;
  import fsp_pkg::*;
  localparam int OPC = 40;
  // sel, write value, expected read
  localparam logic [33:0] ROW_TAB [4] = '{{SEL_CONTROL, 16'h4041, 16'h4041}, {SEL_ADDR_LOW, 16'h1234, 16'h1234},
                                          {SEL_ADDR_HIGH, 16'hABCD, 16'h00CD}, {SEL_KEY, 16'h0055, 16'h0000}};
  logic        clk_sys_in;
  logic        nrst_in;
  logic        ext_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        pready;
  logic        pslverr;
  logic        errv;
  logic        erase;
  logic        prog;
  logic        busy;
  logic [10:0] panel;
  logic [6:0]  row;
  logic [4:0]  idx;
  logic [23:0] wdat;
  logic [23:0] words [32];
  int          error_cnt;
  int          n_compared;
  int          erase_n;
  int          prog_n;
  int          busy_n;
  int          e0;
  int          p0;
  int          b0;

  fsp_link_if u_fsp_link_if ();
  fsp_device #(.OP_CYCLES_P(OPC)) u_fsp_device (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ext_reset_in(ext_rst), .lk(u_fsp_link_if),
    .arr_erase_out(erase), .arr_prog_out(prog), .arr_panel_out(panel), .arr_row_out(row),
    .arr_word_idx_out(idx), .arr_word_data_out(wdat), .busy_out(busy));
  fsp_host u_fsp_host (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .lk(u_fsp_link_if));
  fsp_checker #(.OP_CYCLES_P(OPC)) u_fsp_checker (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ext_reset_in(ext_rst),
    .tw_valid(u_fsp_link_if.tw_valid), .tw_done(u_fsp_link_if.tw_done), .rg_valid(u_fsp_link_if.rg_valid),
    .rg_write(u_fsp_link_if.rg_write), .rg_sel(u_fsp_link_if.rg_sel), .rg_wdata(u_fsp_link_if.rg_wdata),
    .rg_rdata(u_fsp_link_if.rg_rdata), .rg_done(u_fsp_link_if.rg_done), .stall(u_fsp_link_if.stall),
    .done_irq(u_fsp_link_if.done_irq), .irq_clear(u_fsp_link_if.irq_clear));

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // array side sampled mid-cycle so flop updates have landed
  always @(negedge clk_sys_in) begin
    if (prog === 1'b1) begin
      words[idx] = wdat;
      prog_n++;
    end
    if (erase === 1'b1) begin
      erase_n++;
    end
    if (busy === 1'b1) begin
      busy_n++;
    end
  end

  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    // pre-edge values: what the edge that completes the access sees
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // status poll leaves the final status word in rdv
  task automatic cmd(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d);
    apb(1'b1, OFS_ADDR, {8'h00, a});
    apb(1'b1, OFS_WDATA, {16'h0000, d});
    apb(1'b1, OFS_CMD, {29'h0, c});
    do apb(1'b0, OFS_STATUS, 32'h0); while (rdv[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic rd(input logic [1:0] s);
    cmd(CMD_REG_READ, {22'h0, s}, 16'h0000);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_rst = 1'b0;
    nrst_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(SEL_CONTROL);
    chk("ctl_reset", rdv[31:16], CONTROL_RESET);
    rd(SEL_ADDR_LOW);
    chk("adr_reset", rdv[31:16], ADDR_RESET);
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_REG_WRITE, {22'h0, ROW_TAB[i][33:32]}, ROW_TAB[i][31:16]);
      rd(ROW_TAB[i][33:32]);
      chk("reg_row", rdv[31:16], ROW_TAB[i][15:0]);
    end
    cmd(CMD_TBL_LOW, 24'h126040, 16'h0000);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk("host_adr", rdv, 32'h00126040);
    chk("mapped", errv, 1'b0);
    rd(SEL_ADDR_LOW);
    chk("cap_low", rdv[31:16], 16'h6040);
    rd(SEL_ADDR_HIGH);
    chk("cap_high", rdv[31:16], 16'h0012);
    for (int i = 0; i < 32; i++) begin
      cmd(CMD_TBL_LOW, 24'h0062C0 + 24'(2 * i), 16'hA500 + 16'(i));
      cmd(CMD_TBL_HIGH, 24'h0062C0 + 24'(2 * i), {8'hFF, 8'(i)});
    end
    apb(1'b0, OFS_WDATA, 32'h0);
    chk("host_wdat", rdv, 32'h0000FF1F);
    p0 = prog_n;
    b0 = busy_n;
    cmd(CMD_UNLOCK_START, 24'h0, 16'h4001);
    chk("irq_set", rdv[ST_IRQ_BIT], 1'b1);
    chk("prog_cnt", prog_n - p0, 32);
    chk("op_len", busy_n - b0, OPC);
    chk("row", row, 7'h0B);
    chk("panel", panel, 11'h003);
    for (int i = 0; i < 32; i++) begin
      chk("word", words[i], {8'(i), 16'hA500 + 16'(i)});
    end
    rd(SEL_CONTROL);
    chk("start_clr", rdv[31:16], 16'h4001);
    apb(1'b1, OFS_IRQCLR, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("irq_clr", rdv[ST_IRQ_BIT], 1'b0);
    e0 = erase_n;
    p0 = prog_n;
    cmd(CMD_UNLOCK_START, 24'h0, 16'h4041);
    chk("erase_cnt", erase_n - e0, 1);
    chk("erase_prog", prog_n - p0, 0);
    // start without keys, then keys without write enable
    b0 = busy_n;
    cmd(CMD_REG_WRITE, {22'h0, SEL_CONTROL}, 16'hC041);
    cmd(CMD_UNLOCK_START, 24'h0, 16'h0041);
    chk("refused", busy_n - b0, 0);
    rd(SEL_CONTROL);
    chk("refused_ctl", rdv[31:16], 16'h0041);
    b0 = busy_n;
    fork
      begin
        repeat (30) @(posedge clk_sys_in);
        ext_rst <= 1'b1;
        @(posedge clk_sys_in);
        ext_rst <= 1'b0;
      end
    join_none
    cmd(CMD_UNLOCK_START, 24'h0, 16'h4041);
    chk("abort_len", busy_n - b0 < OPC, 1'b1);
    rd(SEL_CONTROL);
    chk("abort_err", rdv[16 + CTL_ERR_BIT], 1'b1);
    rd(SEL_ADDR_LOW);
    chk("abort_adr", rdv[31:16], 16'h62FE);
    apb(1'b1, 12'h020, 32'h0);
    chk("unmapped", errv, 1'b1);
    // reset after the aborted run must also drop the error flag
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(SEL_CONTROL);
    chk("ctl_rereset", rdv[31:16], CONTROL_RESET);
    end_sim();
  end

  // whole run needs a few thousand cycles
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    error_cnt++;
    end_sim();
  end
endmodule
